/* hw/fswc_consts.svh */
// Offsets, field positions and reset values of the self-write controller
`ifndef FSWC_CONSTS_SVH
`define FSWC_CONSTS_SVH
`define FSWC_OFS_TP_LOW   8'h00
`define FSWC_OFS_TP_HIGH  8'h04
`define FSWC_OFS_TP_UPPER 8'h08
`define FSWC_OFS_LATCH    8'h0C
`define FSWC_OFS_CTL      8'h10
`define FSWC_OFS_KEY      8'h14
`define FSWC_OFS_CORE     8'h18
`define FSWC_OFS_PRIO     8'h1C
`define FSWC_OFS_FLAGS    8'h20
`define FSWC_OFS_ENABLES  8'h24
`define FSWC_WORD_MASK    8'hFC
`define FSWC_CTL_PROG     7
`define FSWC_CTL_CFG      6
`define FSWC_CTL_FREE     4
`define FSWC_CTL_ABORT    3
`define FSWC_CTL_WRITE_ENABLE_BIT     2
`define FSWC_CTL_START    1
`define FSWC_CTL_MASK     8'hD4
`define FSWC_UPPER_MASK   8'h3F
`define FSWC_UPPER_CFG    5
`define FSWC_CORE_ALLOW   7
`define FSWC_CORE_MASK    8'h80
`define FSWC_IRQ_BIT      4
`define FSWC_IRQ_MASK     8'h10
`define FSWC_KEY_FIRST    8'h55
`define FSWC_KEY_SECOND   8'hAA
`define FSWC_RST_BYTE     8'h00
`define FSWC_RESP_OKAY    2'h0
`define FSWC_RESP_SLVERR  2'h2
`endif

/* hw/fswc_pkg.sv */
// Types shared by the self-write controller modules
package fswc_pkg;
   typedef logic [7:0] fswc_byte_t;
   typedef logic [7:0] fswc_addr_t;
   typedef enum logic [1:0] {
      FSWC_KEY_IDLE  = 2'h0,
      FSWC_KEY_HALF  = 2'h1,
      FSWC_KEY_ARMED = 2'h3
   } fswc_key_st_t;
   typedef enum logic [1:0] {
      FSWC_SEQ_IDLE = 2'h0,
      FSWC_SEQ_RUN  = 2'h1,
      FSWC_SEQ_END  = 2'h3
   } fswc_seq_st_t;
endpackage

/* hw/fswc_wr_if.sv */
// Register write events passed from the bus slave to the key tracker
`timescale 1ns/1ps
`default_nettype none
interface fswc_wr_if;
   logic             evt;
   logic             is_key;
   fswc_pkg::fswc_byte_t data;
   modport src (output evt, output is_key, output data);
   modport snk (input evt, input is_key, input data);
endinterface
`default_nettype wire

/* hw/fswc_unlock.sv */
// Unlock key tracker: arms only on the two key values back to back
`timescale 1ns/1ps
`default_nettype none
`include "fswc_consts.svh"
module fswc_unlock (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic clr,
   fswc_wr_if.snk    wr,
   output var  logic armed
);
   import fswc_pkg::*;

   fswc_key_st_t st_ff;
   fswc_key_st_t nxt_st;

   // Any other write breaks the sequence, so a stray store disarms
   always_comb begin
      nxt_st = st_ff;
      if (clr) begin
         nxt_st = FSWC_KEY_IDLE;
      end else if (wr.evt) begin
         case (st_ff)
            FSWC_KEY_IDLE: begin
               if (wr.is_key && wr.data == `FSWC_KEY_FIRST) // R01
                  nxt_st = FSWC_KEY_HALF;
            end
            FSWC_KEY_HALF: begin
               if (wr.is_key && wr.data == `FSWC_KEY_SECOND) // R01
                  nxt_st = FSWC_KEY_ARMED;
               else if (wr.is_key && wr.data == `FSWC_KEY_FIRST)
                  nxt_st = FSWC_KEY_HALF;
               else
                  nxt_st = FSWC_KEY_IDLE; // R14
            end
            FSWC_KEY_ARMED: begin
               if (wr.is_key && wr.data == `FSWC_KEY_FIRST)
                  nxt_st = FSWC_KEY_HALF;
               else
                  nxt_st = FSWC_KEY_IDLE; // R14
            end
            default: nxt_st = FSWC_KEY_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!nrst)
         st_ff <= FSWC_KEY_IDLE;
      else
         st_ff <= nxt_st;
   end

   assign armed = (st_ff == FSWC_KEY_ARMED);
endmodule
`default_nettype wire

/* hw/fswc_seq.sv */
// Program cycle sequencer: runs until the array reports done or an abort arrives
`timescale 1ns/1ps
`default_nettype none
module fswc_seq (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic start,
   input  wire logic abort,
   input  wire logic flash_done,
   output var  logic busy,
   output var  logic done_pulse,
   output var  logic abort_pulse
);
   import fswc_pkg::*;

   fswc_seq_st_t st_ff;
   fswc_seq_st_t nxt_st;
   logic         abort_ff;
   logic         nxt_abort;

   // Abort only counts while a cycle is really under way
   always_comb begin
      nxt_st    = st_ff;
      nxt_abort = 1'b0;
      case (st_ff)
         FSWC_SEQ_IDLE: begin
            if (start && !abort)
               nxt_st = FSWC_SEQ_RUN; // R02
         end
         FSWC_SEQ_RUN: begin
            if (abort) begin
               nxt_st    = FSWC_SEQ_IDLE;
               nxt_abort = 1'b1; // R06
            end else if (flash_done) begin
               nxt_st = FSWC_SEQ_END;
            end
         end
         FSWC_SEQ_END: nxt_st = FSWC_SEQ_IDLE;
         default:      nxt_st = FSWC_SEQ_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_ff    <= FSWC_SEQ_IDLE;
         abort_ff <= 1'b0;
      end else begin
         st_ff    <= nxt_st;
         abort_ff <= nxt_abort;
      end
   end

   assign busy        = (st_ff == FSWC_SEQ_RUN); // R02
   assign done_pulse  = (st_ff == FSWC_SEQ_END);
   assign abort_pulse = abort_ff;
endmodule
`default_nettype wire

/* hw/fswc_top.sv */
// Flash self-write controller with AXI4-Lite register slave
// What this block and its software must do
// (R01) Start needs key 0x55 then 0xAA written to the key port just before.
// (R02) Valid start begins programming and stalls the processor until done.
// (R03) Program space set and config select clear targets program Flash.
// (R04) Start is ignored unless write enable is set.
// (R05) Software clears write enable after the cycle completes.
// (R06) Reset pin or watchdog reset during a cycle sets the aborted flag.
// (R07) Table pointer bit 21 steers accesses to configuration space.
// (R08) Table pointer is upper 20:16, high 15:8, low 7:0 bytes.
// (R09) Unimplemented bits of the registers read back as zero.
// (R10) Software may read back and compare programmed data.
// (R11) After power loss or reset, software verifies and reprograms.
// (R12) Software keeps the pointer within the holding block before start.
// (R13) Software masks interrupts around the key writes and start.
// (R14) Any other register write between key steps cancels the unlock.
`timescale 1ns/1ps
`default_nettype none
`include "fswc_consts.svh"
module fswc_top (
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   input  wire fswc_pkg::fswc_addr_t s_axi_awaddr,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   output var  logic [1:0]           s_axi_bresp,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   input  wire fswc_pkg::fswc_addr_t s_axi_araddr,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp,
   input  wire logic                 external_reset_pin,
   input  wire logic                 watchdog_timeout,
   input  wire logic                 flash_done,
   output var  logic                 flash_start,
   output var  logic                 flash_abort,
   output var  logic [20:0]          flash_addr,
   output var  logic                 flash_cfg_access,
   output var  logic                 flash_prog_access,
   output var  logic                 flash_row_erase,
   output var  fswc_pkg::fswc_byte_t flash_data,
   output var  logic                 cpu_stall,
   output var  logic                 global_irq_allow,
   output var  logic                 nvm_done_priority,
   output var  logic                 irq
);
   import fswc_pkg::*;

   fswc_wr_if wr_bus ();

   // Bus slave state
   logic       aw_full_ff, nxt_aw_full;
   logic       w_full_ff, nxt_w_full;
   fswc_addr_t waddr_ff, nxt_waddr;
   fswc_byte_t wdata_ff, nxt_wdata;
   logic       wstrb_ff, nxt_wstrb;
   logic       bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic       rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;

   // Register file state
   fswc_byte_t tp_low_ff, nxt_tp_low;
   fswc_byte_t tp_high_ff, nxt_tp_high;
   fswc_byte_t tp_upper_ff, nxt_tp_upper;
   fswc_byte_t latch_ff, nxt_latch;
   fswc_byte_t ctl_ff, nxt_ctl;
   fswc_byte_t core_ff, nxt_core;
   fswc_byte_t prio_ff, nxt_prio;
   fswc_byte_t flags_ff, nxt_flags;
   fswc_byte_t enables_ff, nxt_enables;
   logic       start_ff, nxt_start;

   logic       wr_fire;
   logic       wr_ok;
   fswc_addr_t wword;
   fswc_addr_t rword;
   logic       rd_hit;
   fswc_byte_t rd_byte;
   logic       key_armed;
   logic       start_go;
   logic       ext_rst;
   logic       busy;
   logic       done_pulse;
   logic       abort_pulse;

   // Write fires once address and data are both held and no reply waits
   assign wr_fire = aw_full_ff && w_full_ff && !bvalid_ff;
   assign wword   = waddr_ff & `FSWC_WORD_MASK;
   assign rword   = s_axi_araddr & `FSWC_WORD_MASK;
   assign ext_rst = external_reset_pin || watchdog_timeout;

   // Decode of the held write address
   always_comb begin
      case (wword)
         `FSWC_OFS_TP_LOW, `FSWC_OFS_TP_HIGH, `FSWC_OFS_TP_UPPER,
         `FSWC_OFS_LATCH, `FSWC_OFS_CTL, `FSWC_OFS_KEY,
         `FSWC_OFS_CORE, `FSWC_OFS_PRIO, `FSWC_OFS_FLAGS,
         `FSWC_OFS_ENABLES: wr_ok = 1'b1;
         default:           wr_ok = 1'b0;
      endcase
   end

   // Every register write with byte lane 0 strobed is shown to the key tracker
   assign wr_bus.evt    = wr_fire && wr_ok && wstrb_ff;
   assign wr_bus.is_key = (wword == `FSWC_OFS_KEY);
   assign wr_bus.data   = wdata_ff;

   fswc_unlock u_unlock (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .clr     (ext_rst),
      .wr      (wr_bus),
      .armed   (key_armed)
   );

   // Start needs the key armed, enable already set and kept set, idle
   assign start_go = wr_bus.evt && (wword == `FSWC_OFS_CTL)
                     && wdata_ff[`FSWC_CTL_START]
                     && key_armed // R01
                     && ctl_ff[`FSWC_CTL_WRITE_ENABLE_BIT]
                     && wdata_ff[`FSWC_CTL_WRITE_ENABLE_BIT] // R04
                     && !busy && !ext_rst;

   fswc_seq u_seq (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .start       (start_ff),
      .abort       (ext_rst),
      .flash_done  (flash_done),
      .busy        (busy),
      .done_pulse  (done_pulse),
      .abort_pulse (abort_pulse)
   );

   // Read mux; hidden bits are masked off so they read as zero
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = `FSWC_RST_BYTE;
      case (rword)
         `FSWC_OFS_TP_LOW:   rd_byte = tp_low_ff;
         `FSWC_OFS_TP_HIGH:  rd_byte = tp_high_ff;
         `FSWC_OFS_TP_UPPER: rd_byte = tp_upper_ff & `FSWC_UPPER_MASK; // R09
         `FSWC_OFS_LATCH:    rd_byte = latch_ff;
         `FSWC_OFS_CTL: begin
            rd_byte = ctl_ff & `FSWC_CTL_MASK; // R09
            rd_byte[`FSWC_CTL_ABORT] = ctl_ff[`FSWC_CTL_ABORT];
            rd_byte[`FSWC_CTL_START] = busy || start_ff;
         end
         `FSWC_OFS_KEY:      rd_byte = `FSWC_RST_BYTE;
         `FSWC_OFS_CORE:     rd_byte = core_ff & `FSWC_CORE_MASK; // R09
         `FSWC_OFS_PRIO:     rd_byte = prio_ff & `FSWC_IRQ_MASK; // R09
         `FSWC_OFS_FLAGS:    rd_byte = flags_ff & `FSWC_IRQ_MASK; // R09
         `FSWC_OFS_ENABLES:  rd_byte = enables_ff & `FSWC_IRQ_MASK; // R09
         default:            rd_hit = 1'b0;
      endcase
   end

   // Bus channel next values; reply answers a write one cycle after fire
   always_comb begin
      nxt_aw_full = aw_full_ff;
      nxt_w_full  = w_full_ff;
      nxt_waddr   = waddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      if (s_axi_awvalid && !aw_full_ff) begin
         nxt_aw_full = 1'b1;
         nxt_waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_ff) begin
         nxt_w_full = 1'b1;
         nxt_wdata  = s_axi_wdata[7:0];
         nxt_wstrb  = s_axi_wstrb[0];
      end
      if (bvalid_ff && s_axi_bready)
         nxt_bvalid = 1'b0;
      if (wr_fire) begin
         nxt_aw_full = 1'b0;
         nxt_w_full  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = wr_ok ? `FSWC_RESP_OKAY : `FSWC_RESP_SLVERR;
      end
      if (rvalid_ff && s_axi_rready)
         nxt_rvalid = 1'b0;
      if (s_axi_arvalid && !rvalid_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rdata  = {24'h000000, rd_byte};
         nxt_rresp  = rd_hit ? `FSWC_RESP_OKAY : `FSWC_RESP_SLVERR;
      end
   end

   // Bus channel registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         aw_full_ff <= 1'b0;
         w_full_ff  <= 1'b0;
         waddr_ff   <= `FSWC_RST_BYTE;
         wdata_ff   <= `FSWC_RST_BYTE;
         wstrb_ff   <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `FSWC_RESP_OKAY;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= `FSWC_RESP_OKAY;
      end else begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff  <= nxt_w_full;
         waddr_ff   <= nxt_waddr;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end
   end

   // Register next values; hardware sets win over software clears
   always_comb begin
      nxt_tp_low   = tp_low_ff;
      nxt_tp_high  = tp_high_ff;
      nxt_tp_upper = tp_upper_ff;
      nxt_latch    = latch_ff;
      nxt_ctl      = ctl_ff;
      nxt_core     = core_ff;
      nxt_prio     = prio_ff;
      nxt_flags    = flags_ff;
      nxt_enables  = enables_ff;
      nxt_start    = start_go;
      if (wr_bus.evt) begin
         case (wword)
            `FSWC_OFS_TP_LOW:   nxt_tp_low = wdata_ff;
            `FSWC_OFS_TP_HIGH:  nxt_tp_high = wdata_ff;
            `FSWC_OFS_TP_UPPER: nxt_tp_upper = wdata_ff & `FSWC_UPPER_MASK;
            `FSWC_OFS_LATCH:    nxt_latch = wdata_ff;
            `FSWC_OFS_CTL: begin
               nxt_ctl = wdata_ff & `FSWC_CTL_MASK;
               // Abort flag is only cleared by software, never set
               nxt_ctl[`FSWC_CTL_ABORT] = ctl_ff[`FSWC_CTL_ABORT]
                                          && wdata_ff[`FSWC_CTL_ABORT];
            end
            `FSWC_OFS_CORE:     nxt_core = wdata_ff & `FSWC_CORE_MASK;
            `FSWC_OFS_PRIO:     nxt_prio = wdata_ff & `FSWC_IRQ_MASK;
            `FSWC_OFS_FLAGS:    nxt_flags = flags_ff & ~wdata_ff;
            `FSWC_OFS_ENABLES:  nxt_enables = wdata_ff & `FSWC_IRQ_MASK;
            default:            nxt_ctl = ctl_ff;
         endcase
      end
      if (done_pulse)
         nxt_flags[`FSWC_IRQ_BIT] = 1'b1;
      // Outside reset clears control but keeps the evidence of the loss
      if (ext_rst) begin
         nxt_ctl = `FSWC_RST_BYTE;
         nxt_ctl[`FSWC_CTL_ABORT] = ctl_ff[`FSWC_CTL_ABORT];
      end
      if (abort_pulse)
         nxt_ctl[`FSWC_CTL_ABORT] = 1'b1; // R06
   end

   // Register file
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tp_low_ff   <= `FSWC_RST_BYTE;
         tp_high_ff  <= `FSWC_RST_BYTE;
         tp_upper_ff <= `FSWC_RST_BYTE;
         latch_ff    <= `FSWC_RST_BYTE;
         ctl_ff      <= `FSWC_RST_BYTE;
         core_ff     <= `FSWC_RST_BYTE;
         prio_ff     <= `FSWC_RST_BYTE;
         flags_ff    <= `FSWC_RST_BYTE;
         enables_ff  <= `FSWC_RST_BYTE;
         start_ff    <= 1'b0;
      end else begin
         tp_low_ff   <= nxt_tp_low;
         tp_high_ff  <= nxt_tp_high;
         tp_upper_ff <= nxt_tp_upper;
         latch_ff    <= nxt_latch;
         ctl_ff      <= nxt_ctl;
         core_ff     <= nxt_core;
         prio_ff     <= nxt_prio;
         flags_ff    <= nxt_flags;
         enables_ff  <= nxt_enables;
         start_ff    <= nxt_start;
      end
   end

   // Flash side; stall covers the start cycle too so no fetch slips in
   assign flash_addr        = {tp_upper_ff[4:0], tp_high_ff, tp_low_ff}; // R08
   assign flash_cfg_access  = ctl_ff[`FSWC_CTL_CFG]
                              || tp_upper_ff[`FSWC_UPPER_CFG]; // R07
   assign flash_prog_access = ctl_ff[`FSWC_CTL_PROG]
                              && !flash_cfg_access; // R03
   assign flash_row_erase   = ctl_ff[`FSWC_CTL_FREE];
   assign flash_data        = latch_ff;
   assign flash_start       = start_ff; // R02
   assign flash_abort       = abort_pulse;
   assign cpu_stall         = start_ff || busy; // R02

   // Interrupt and bus outputs
   assign global_irq_allow  = core_ff[`FSWC_CORE_ALLOW];
   assign nvm_done_priority = prio_ff[`FSWC_IRQ_BIT];
   assign irq               = |(flags_ff & enables_ff & `FSWC_IRQ_MASK);
   assign s_axi_awready     = !aw_full_ff;
   assign s_axi_wready      = !w_full_ff;
   assign s_axi_bvalid      = bvalid_ff;
   assign s_axi_bresp       = bresp_ff;
   assign s_axi_arready     = !rvalid_ff;
   assign s_axi_rvalid      = rvalid_ff;
   assign s_axi_rdata       = rdata_ff;
   assign s_axi_rresp       = rresp_ff;
endmodule
`default_nettype wire

/* verification/fswc_chk.sv */
// Port-level assertions for the flash self-write controller
`timescale 1ns/1ps
`default_nettype none
module fswc_chk (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        external_reset_pin,
   input wire logic        watchdog_timeout,
   input wire logic        flash_done,
   input wire logic        flash_start,
   input wire logic        flash_abort,
   input wire logic        flash_cfg_access,
   input wire logic        flash_prog_access,
   input wire logic        cpu_stall,
   input wire logic        irq
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_start_stalls: assert property (flash_start |-> cpu_stall)
      else $error("start pulse without cpu stall");
   a_stall_cause: assert property ($rose(cpu_stall) |-> flash_start)
      else $error("stall rose without a start pulse");
   a_start_single: assert property (flash_start |=> !flash_start)
      else $error("start pulse longer than one cycle");
   // Done ends the stall one cycle later; the start cycle itself is excluded
   a_done_release: assert property (
      cpu_stall && flash_done && !flash_start |=> !cpu_stall)
      else $error("stall outlived the done indication");
   a_prog_target: assert property (flash_prog_access |-> !flash_cfg_access)
      else $error("program and config access both selected");
   a_abort_cause: assert property (
      flash_abort |-> $past(external_reset_pin || watchdog_timeout))
      else $error("abort pulse without an outside reset");
   a_rd_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data above bit 7 not zero");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed early");
   a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped or changed early");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
      else $error("write answer not two cycles after handshake");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid)
      else $error("read answer not one cycle after handshake");

   c_start: cover property (flash_start);
   c_abort: cover property (flash_abort);
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind fswc_top fswc_chk u_fswc_chk (
   .clk_sys(clk_sys), .nrst(nrst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .external_reset_pin(external_reset_pin),
   .watchdog_timeout(watchdog_timeout), .flash_done(flash_done),
   .flash_start(flash_start), .flash_abort(flash_abort),
   .flash_cfg_access(flash_cfg_access),
   .flash_prog_access(flash_prog_access), .cpu_stall(cpu_stall),
   .irq(irq));
`default_nettype wire

/* verification/fswc_tb_top.sv */
// Self-checking bench for the flash self-write controller
`timescale 1ns/1ps
`default_nettype none
`include "fswc_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
   error_cnt++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); \
   end end
module fswc_tb_top;
   import fswc_pkg::*;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        brdy = 1'b0;
   logic        arv = 1'b0;
   logic        rrdy = 1'b0;
   fswc_addr_t  awa = 8'h00;
   fswc_addr_t  ara = 8'h00;
   logic [31:0] wd = 32'h00000000;
   logic        ext_rst = 1'b0;
   logic        wdt = 1'b0;
   logic        done = 1'b0;
   logic        awr, wr_rdy, bv, arr, rv, fst, fab, cfg, prg, ers;
   logic        stall, gia, pri, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [20:0] faddr;
   fswc_byte_t  fdata;
   int          error_cnt = 0;
   int          check_count = 0;
   int          start_cnt = 0;
   int          abort_cnt = 0;
   // Key steps: 55/AA go to the key port, anything else to pointer low
   fswc_byte_t  ks[7][3] = '{'{8'h55, 8'h55, 8'hAA},
      '{8'h55, 8'hAA, 8'h55}, '{8'h55, 8'h11, 8'hAA},
      '{8'h55, 8'hAA, 8'h22}, '{8'hAA, 8'hAA, 8'hAA},
      '{8'h33, 8'h55, 8'hAA}, '{8'hAA, 8'h55, 8'hAA}};

   fswc_top u_fswc_top (
      .clk_sys(clk_sys), .nrst(nrst),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
      .s_axi_wstrb(4'h1), .s_axi_bvalid(bv), .s_axi_bready(brdy),
      .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .external_reset_pin(ext_rst), .watchdog_timeout(wdt),
      .flash_done(done), .flash_start(fst), .flash_abort(fab),
      .flash_addr(faddr), .flash_cfg_access(cfg),
      .flash_prog_access(prg), .flash_row_erase(ers), .flash_data(fdata),
      .cpu_stall(stall), .global_irq_allow(gia),
      .nvm_done_priority(pri), .irq(irq));

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   // Pulses are one cycle wide, so count them on every edge
   always @(posedge clk_sys) begin
      if (fst === 1'b1) start_cnt++;
      if (fab === 1'b1) abort_cnt++;
   end

   // AXI write: address and data offered together, each dropped when taken
   task automatic wr(input fswc_addr_t a, input fswc_byte_t d,
                     input logic [1:0] er = `FSWC_RESP_OKAY);
      bit ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      awa <= a;
      wd <= {24'h000000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge clk_sys);
         if (awv && awr) begin
            ta = 1'b1;
            awv <= 1'b0;
         end
         if (wv && wr_rdy) begin
            tw = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (bv !== 1'b1);
      `CHK(bresp, er)
   endtask

   // AXI read with expected byte and response
   task automatic rd(input fswc_addr_t a, input fswc_byte_t e,
                     input logic [1:0] er = `FSWC_RESP_OKAY);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do @(posedge clk_sys); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk_sys); while (rv !== 1'b1);
      `CHK(rdata, {24'h000000, e})
      `CHK(rresp, er)
   endtask

   // Array reports completion after a random program time
   task automatic finish_cycle();
      repeat ($urandom_range(20, 2)) @(posedge clk_sys);
      done <= 1'b1;
      @(posedge clk_sys);
      done <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic summarize();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      fswc_byte_t v[4];
      int         c0;
      void'($urandom(32'h4859));
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 10; i++)
         rd(8'(4 * i), 8'h00);
      rd(8'h28, 8'h00, `FSWC_RESP_SLVERR);
      wr(8'h30, 8'h5A, `FSWC_RESP_SLVERR);
      // Random register contents, all ones first as the corner
      for (int n = 0; n < 6; n++) begin
         foreach (v[k]) v[k] = 8'($urandom);
         if (n == 0) v = '{default: 8'hFF};
         wr(`FSWC_OFS_TP_LOW, v[0]);
         wr(`FSWC_OFS_TP_HIGH, v[1]);
         wr(`FSWC_OFS_TP_UPPER, v[2]);
         wr(`FSWC_OFS_LATCH, v[3]);
         wr(`FSWC_OFS_CORE, v[0]);
         wr(`FSWC_OFS_PRIO, v[1]);
         wr(`FSWC_OFS_ENABLES, v[2]);
         rd(`FSWC_OFS_TP_UPPER, v[2] & 8'h3F);
         rd(`FSWC_OFS_CORE, v[0] & 8'h80);
         rd(`FSWC_OFS_PRIO, v[1] & 8'h10);
         rd(`FSWC_OFS_ENABLES, v[2] & 8'h10);
         `CHK(faddr, {v[2][4:0], v[1], v[0]})
         `CHK(cfg, v[2][5])
         `CHK(fdata, v[3])
         `CHK(gia, v[0][7])
         `CHK(pri, v[1][4])
         `CHK(irq, 1'b0)
      end
      // Space selection from control and from pointer bit 21
      wr(`FSWC_OFS_TP_UPPER, 8'h00);
      wr(`FSWC_OFS_CTL, 8'hF7);
      rd(`FSWC_OFS_CTL, 8'hD4);
      `CHK(prg, 1'b0)
      `CHK(ers, 1'b1)
      wr(`FSWC_OFS_CTL, 8'h80);
      `CHK(prg, 1'b1)
      wr(`FSWC_OFS_TP_UPPER, 8'h20);
      `CHK(cfg, 1'b1)
      `CHK(prg, 1'b0)
      wr(`FSWC_OFS_TP_UPPER, 8'h00);
      wr(`FSWC_OFS_ENABLES, 8'h10);
      wr(`FSWC_OFS_CORE, 8'h00);
      // Key sequences: only 0 and 6 may start, 5 lacks prior enable
      for (int i = 0; i < 7; i++) begin
         wr(`FSWC_OFS_CTL, (i == 5) ? 8'h80 : 8'h84);
         c0 = start_cnt;
         for (int j = 0; j < 3; j++)
            wr((ks[i][j] inside {8'h55, 8'hAA}) ?
               `FSWC_OFS_KEY : `FSWC_OFS_TP_LOW, ks[i][j]);
         wr(`FSWC_OFS_CTL, 8'h86);
         `CHK(stall, i == 0 || i == 6)
         repeat (2) @(posedge clk_sys);
         `CHK(start_cnt - c0, int'(i == 0 || i == 6))
         if (i == 0 || i == 6) begin
            `CHK(prg, 1'b1)
            finish_cycle();
            `CHK(stall, 1'b0)
            `CHK(irq, 1'b1)
            rd(`FSWC_OFS_FLAGS, 8'h10);
            wr(`FSWC_OFS_ENABLES, 8'h00);
            `CHK(irq, 1'b0)
            wr(`FSWC_OFS_ENABLES, 8'h10);
            `CHK(irq, 1'b1)
            wr(`FSWC_OFS_FLAGS, 8'h10);
            `CHK(irq, 1'b0)
         end
         wr(`FSWC_OFS_CTL, 8'h80);
      end
      // Outside reset in mid-cycle: pin first, then watchdog
      for (int s = 0; s < 2; s++) begin
         wr(`FSWC_OFS_CTL, 8'h84);
         wr(`FSWC_OFS_KEY, 8'h55);
         wr(`FSWC_OFS_KEY, 8'hAA);
         wr(`FSWC_OFS_CTL, 8'h86);
         c0 = abort_cnt;
         repeat ($urandom_range(9, 1)) @(posedge clk_sys);
         ext_rst <= (s == 0);
         wdt <= (s == 1);
         @(posedge clk_sys);
         ext_rst <= 1'b0;
         wdt <= 1'b0;
         repeat (4) @(posedge clk_sys);
         `CHK(abort_cnt - c0, 1)
         rd(`FSWC_OFS_CTL, 8'h08);
         wr(`FSWC_OFS_CTL, 8'h00);
         rd(`FSWC_OFS_CTL, 8'h00);
      end
      summarize();
   end

   // Hang guard, well past the run's length
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
